// [rtl/txfc_pkg.sv]
// constants for the transmit frame control decode block
package txfc_pkg;

  // ************************************************************
  // per-packet control byte fields
  // ************************************************************
  localparam int CTL_OVERRIDE_BIT = 0;
  localparam int CTL_FCS_BIT      = 1;
  localparam int CTL_PAD_BIT      = 2;
  localparam int CTL_OVERSIZE_BIT = 3;

  // ************************************************************
  // wire framing constants
  // ************************************************************
  localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
  localparam logic [7:0] SFD_BYTE      = 8'hd5;
  localparam logic [7:0] PAD_BYTE      = 8'h00;
  localparam logic [2:0] PRE_LAST_IDX  = 3'h7; // seven preamble bytes, then delimiter
  localparam logic [1:0] FCS_LAST_IDX  = 2'h3; // four check bytes
  localparam logic [6:0] PAD_LEN_SHORT = 7'h3c; // 60 bytes
  localparam logic [6:0] PAD_LEN_LONG  = 7'h40; // 64 bytes

  // ************************************************************
  // global pad configuration codes and tag detection
  // ************************************************************
  localparam logic [2:0] PADCFG_60      = 3'h1;
  localparam logic [2:0] PADCFG_VLAN    = 3'h5;
  localparam logic [7:0] VLAN_TYPE_HI   = 8'h81;
  localparam logic [7:0] VLAN_TYPE_LO   = 8'h00;
  localparam int         TYPE_HI_IDX    = 12;
  localparam int         TYPE_LO_IDX    = 13;

  // ************************************************************
  // crc-32 (reflected form)
  // ************************************************************
  localparam logic [31:0] CRC_POLY    = 32'hedb88320;
  localparam logic [31:0] CRC_INIT    = 32'hffffffff;
  localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;

  // ************************************************************
  // frame engine states
  // ************************************************************
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_PRE   = 6'h02,
    ST_DATA  = 6'h04,
    ST_PAD   = 6'h08,
    ST_FCS   = 6'h10,
    ST_DRAIN = 6'h20
  } txfc_state_type;

endpackage

// [rtl/txfc_tx_frame.sv]
// transmit frame assembly: control byte decode, preamble, pad, crc and length limit
`timescale 1ns/1ps
`default_nettype none
module txfc_tx_frame #(
  parameter int CNT_W = 16
) (
  input  wire logic             mclk_in,
  input  wire logic             rst_in,
  input  wire logic [7:0]       buf_data_in,
  input  wire logic             buf_valid_in,
  input  wire logic             buf_last_in,
  output logic                  buf_ready_out,
  input  wire logic [2:0]       cfg_pad_mode_in,
  input  wire logic             cfg_fcs_enable_in,
  input  wire logic             cfg_oversize_allow_in,
  input  wire logic [CNT_W-1:0] max_frame_length_in,
  output logic [7:0]            wire_data_out,
  output logic                  wire_valid_out,
  output logic                  wire_end_out,
  output logic                  frame_done_out,
  output logic                  frame_abort_out,
  output logic                  fcs_bad_out,
  output logic                  busy_out
);

  // ************************************************************
  // elaboration checks
  // ************************************************************
  if (CNT_W < 7) begin : g_bad_width
    $error("txfc_tx_frame: CNT_W must be at least 7");
  end

  // one crc-32 byte step
  function automatic logic [31:0] crc_step(input logic [31:0] crc, input logic [7:0] d);
    logic [31:0] c;
    c = crc ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ txfc_pkg::CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  // ************************************************************
  // state and frame settings
  // ************************************************************
  txfc_pkg::txfc_state_type state;
  txfc_pkg::txfc_state_type next_state;
  logic [CNT_W-1:0]         byte_cnt;
  logic [2:0]               sub_cnt;
  logic [31:0]              crc;
  logic [31:0]              next_crc;
  logic                     pkt_pad_enable;
  logic                     pkt_fcs_enable;
  logic                     pkt_oversize_allow;
  logic                     pkt_settings_override;
  logic [2:0]               pad_mode;
  logic                     vlan_hi;
  logic                     vlan_seen;
  logic                     take;
  logic [6:0]               pad_len;
  logic                     pad_on;
  logic                     pad_short;
  logic                     at_max;

  assign take = buf_valid_in && buf_ready_out;

  // pad target: per-packet pads to 60, global mode picks 60, 64 or tag-dependent
  always_comb begin
    if (pkt_settings_override) begin
      pad_len = txfc_pkg::PAD_LEN_SHORT;
    end else if (pad_mode == txfc_pkg::PADCFG_60) begin
      pad_len = txfc_pkg::PAD_LEN_SHORT;
    end else if (pad_mode == txfc_pkg::PADCFG_VLAN) begin
      pad_len = vlan_seen ? txfc_pkg::PAD_LEN_LONG : txfc_pkg::PAD_LEN_SHORT;
    end else begin
      pad_len = txfc_pkg::PAD_LEN_LONG;
    end
  end

  // padding applies to the frame only while it is below the target
  assign pad_on    = pkt_pad_enable;
  assign pad_short = (CNT_W'(byte_cnt + 1'b1) < CNT_W'(pad_len));
  assign at_max    = !pkt_oversize_allow && (CNT_W'(byte_cnt + 1'b1) >= max_frame_length_in);

  // crc value after the byte being emitted this cycle
  always_comb begin
    next_crc = crc;
    if (state == txfc_pkg::ST_DATA && take) begin
      next_crc = crc_step(crc, buf_data_in);
    end else if (state == txfc_pkg::ST_PAD) begin
      next_crc = crc_step(crc, txfc_pkg::PAD_BYTE);
    end
  end

  // next state
  always_comb begin
    next_state = state;
    unique case (state)
      txfc_pkg::ST_IDLE: begin
        if (take) next_state = txfc_pkg::ST_PRE;
      end
      txfc_pkg::ST_PRE: begin
        if (sub_cnt == txfc_pkg::PRE_LAST_IDX) next_state = txfc_pkg::ST_DATA;
      end
      txfc_pkg::ST_DATA: begin
        if (take) begin
          if (buf_last_in) begin
            if (pad_on && pad_short) next_state = txfc_pkg::ST_PAD;
            else if (pkt_fcs_enable) next_state = txfc_pkg::ST_FCS;
            else next_state = txfc_pkg::ST_IDLE;
          end else if (at_max) begin
            next_state = txfc_pkg::ST_DRAIN;
          end
        end
      end
      txfc_pkg::ST_PAD: begin
        if (!pad_short) begin
          next_state = pkt_fcs_enable ? txfc_pkg::ST_FCS : txfc_pkg::ST_IDLE;
        end
      end
      txfc_pkg::ST_FCS: begin
        if (sub_cnt[1:0] == txfc_pkg::FCS_LAST_IDX) next_state = txfc_pkg::ST_IDLE;
      end
      txfc_pkg::ST_DRAIN: begin
        if (take && buf_last_in) next_state = txfc_pkg::ST_IDLE;
      end
    endcase
  end

  // ************************************************************
  // sequential logic
  // ************************************************************

  // state register
  always_ff @(posedge mclk_in) begin
    if (rst_in) state <= txfc_pkg::ST_IDLE;
    else state <= next_state;
  end

  // buffer is read only where its bytes are wanted
  always_ff @(posedge mclk_in) begin
    if (rst_in) buf_ready_out <= 1'b0;
    else buf_ready_out <= (next_state == txfc_pkg::ST_IDLE) || (next_state == txfc_pkg::ST_DATA)
                          || (next_state == txfc_pkg::ST_DRAIN);
  end

  // control byte decode, with override choosing the source of each setting
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      pkt_settings_override <= 1'b0;
      pkt_pad_enable        <= 1'b0;
      pkt_fcs_enable        <= 1'b0;
      pkt_oversize_allow    <= 1'b0;
      pad_mode              <= 3'h0;
    end else if (state == txfc_pkg::ST_IDLE && take) begin
      pad_mode              <= cfg_pad_mode_in;
      pkt_settings_override <= buf_data_in[txfc_pkg::CTL_OVERRIDE_BIT];
      if (buf_data_in[txfc_pkg::CTL_OVERRIDE_BIT]) begin
        pkt_pad_enable     <= buf_data_in[txfc_pkg::CTL_PAD_BIT];
        pkt_fcs_enable     <= buf_data_in[txfc_pkg::CTL_FCS_BIT];
        pkt_oversize_allow <= buf_data_in[txfc_pkg::CTL_OVERSIZE_BIT];
      end else begin
        pkt_pad_enable     <= cfg_pad_mode_in[0];
        pkt_fcs_enable     <= cfg_fcs_enable_in;
        pkt_oversize_allow <= cfg_oversize_allow_in;
      end
    end
  end

  // byte and sub counters
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      byte_cnt <= '0;
      sub_cnt  <= 3'h0;
    end else begin
      if (state == txfc_pkg::ST_IDLE) byte_cnt <= '0;
      else if ((state == txfc_pkg::ST_DATA && take) || state == txfc_pkg::ST_PAD)
        byte_cnt <= CNT_W'(byte_cnt + 1'b1);
      if (state != next_state) sub_cnt <= 3'h0;
      else if (state == txfc_pkg::ST_PRE || state == txfc_pkg::ST_FCS)
        sub_cnt <= 3'(sub_cnt + 1'b1);
    end
  end

  // crc accumulation and tag detection on the type field
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      crc       <= txfc_pkg::CRC_INIT;
      vlan_hi   <= 1'b0;
      vlan_seen <= 1'b0;
    end else if (state == txfc_pkg::ST_IDLE) begin
      crc       <= txfc_pkg::CRC_INIT;
      vlan_hi   <= 1'b0;
      vlan_seen <= 1'b0;
    end else begin
      crc <= next_crc;
      if (state == txfc_pkg::ST_DATA && take && byte_cnt == CNT_W'(txfc_pkg::TYPE_HI_IDX))
        vlan_hi <= (buf_data_in == txfc_pkg::VLAN_TYPE_HI);
      if (state == txfc_pkg::ST_DATA && take && byte_cnt == CNT_W'(txfc_pkg::TYPE_LO_IDX))
        vlan_seen <= vlan_hi && (buf_data_in == txfc_pkg::VLAN_TYPE_LO);
    end
  end

  // wire byte output; the control byte is swallowed in idle
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      wire_data_out  <= 8'h00;
      wire_valid_out <= 1'b0;
      wire_end_out   <= 1'b0;
    end else begin
      wire_valid_out <= 1'b0;
      wire_end_out   <= 1'b0;
      unique case (state)
        txfc_pkg::ST_IDLE: begin
          wire_data_out <= 8'h00;
        end
        txfc_pkg::ST_PRE: begin
          wire_valid_out <= 1'b1;
          wire_data_out  <= (sub_cnt == txfc_pkg::PRE_LAST_IDX) ? txfc_pkg::SFD_BYTE
                                                                  : txfc_pkg::PREAMBLE_BYTE;
        end
        txfc_pkg::ST_DATA: begin
          wire_valid_out <= take;
          wire_data_out  <= buf_data_in;
          wire_end_out   <= take && next_state == txfc_pkg::ST_IDLE;
        end
        txfc_pkg::ST_PAD: begin
          wire_valid_out <= 1'b1;
          wire_data_out  <= txfc_pkg::PAD_BYTE;
          wire_end_out   <= next_state == txfc_pkg::ST_IDLE;
        end
        txfc_pkg::ST_FCS: begin
          wire_valid_out <= 1'b1;
          wire_data_out  <= ~crc[8*sub_cnt[1:0] +: 8];
          wire_end_out   <= next_state == txfc_pkg::ST_IDLE;
        end
        txfc_pkg::ST_DRAIN: begin
          wire_data_out <= 8'h00;
        end
      endcase
    end
  end

  // completion, abort and check results
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      frame_done_out  <= 1'b0;
      frame_abort_out <= 1'b0;
      fcs_bad_out     <= 1'b0;
      busy_out        <= 1'b0;
    end else begin
      busy_out        <= next_state != txfc_pkg::ST_IDLE;
      frame_abort_out <= state == txfc_pkg::ST_DATA && next_state == txfc_pkg::ST_DRAIN;
      frame_done_out  <= state != txfc_pkg::ST_IDLE && state != txfc_pkg::ST_PRE
                         && next_state == txfc_pkg::ST_IDLE;
      if (state == txfc_pkg::ST_IDLE && take) fcs_bad_out <= 1'b0;
      else if ((state == txfc_pkg::ST_DATA || state == txfc_pkg::ST_PAD)
               && next_state == txfc_pkg::ST_IDLE && !pkt_fcs_enable)
        fcs_bad_out <= next_crc != txfc_pkg::CRC_RESIDUE;
    end
  end

endmodule
`default_nettype wire

// [verification/txfc_tx_frame_props.sv]
// assertion checker for the transmit frame control decode block
`timescale 1ns/1ps
`default_nettype none
module txfc_tx_frame_props #(
  parameter int CNT_W = 16
) (
  input wire logic             mclk_in,
  input wire logic             rst_in,
  input wire logic [7:0]       buf_data_in,
  input wire logic             buf_valid_in,
  input wire logic             buf_last_in,
  input wire logic             buf_ready_out,
  input wire logic [2:0]       cfg_pad_mode_in,
  input wire logic             cfg_fcs_enable_in,
  input wire logic             cfg_oversize_allow_in,
  input wire logic [CNT_W-1:0] max_frame_length_in,
  input wire logic [7:0]       wire_data_out,
  input wire logic             wire_valid_out,
  input wire logic             wire_end_out,
  input wire logic             frame_done_out,
  input wire logic             frame_abort_out,
  input wire logic             fcs_bad_out,
  input wire logic             busy_out
);
  // ************************************************************
  // helper logic and properties
  // ************************************************************
  logic draining;
  logic ctl_take;
  // window between an abort and the closing done
  always_ff @(posedge mclk_in) begin
    if (rst_in || frame_done_out) begin
      draining <= 1'b0;
    end else if (frame_abort_out) begin
      draining <= 1'b1;
    end
  end
  // control byte accepted while idle
  assign ctl_take = buf_valid_in && buf_ready_out && !busy_out;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  pre_seq_a:
    assert property (ctl_take |=> ##1 (wire_valid_out && wire_data_out == 8'h55) [*7]
      ##1 (wire_valid_out && wire_data_out == txfc_pkg::SFD_BYTE)) else $error("bad preamble");
  pre_stall_a:
    assert property (ctl_take |=> !buf_ready_out [*7]) else $error("ready during preamble");
  data_echo_a:
    assert property (busy_out && buf_valid_in && buf_ready_out && !draining && !frame_abort_out
      |=> wire_valid_out && wire_data_out == $past(buf_data_in)) else $error("byte not echoed");
  end_done_a:
    assert property (wire_end_out |-> frame_done_out && wire_valid_out) else $error("end alone");
  drain_quiet_a:
    assert property (draining |-> !wire_valid_out && !wire_end_out) else $error("drain on wire");
  abort_pulse_a:
    assert property (frame_abort_out |=> !frame_abort_out && busy_out) else $error("abort shape");
  fcs_clear_a:
    assert property (ctl_take |=> !fcs_bad_out) else $error("check flag kept");
  busy_start_a:
    assert property ($rose(busy_out) |-> $past(buf_valid_in && buf_ready_out))
      else $error("busy without byte");
  cover property (frame_abort_out);
  cover property (wire_end_out);
  cover property ($rose(fcs_bad_out));
endmodule
`default_nettype wire

// [verification/txfc_host_model.sv]
// host model that offers buffered frames byte by byte
`timescale 1ns/1ps
`default_nettype none
module txfc_host_model (
  input  wire logic       mclk_in,
  input  wire logic       go_in,
  input  wire logic       slow_in,
  input  wire logic [7:0] len_in,
  input  wire logic       buf_ready_in,
  output logic [7:0]      buf_data_out,
  output logic            buf_valid_out,
  output logic            buf_last_out
);
  logic [7:0] mem [0:255];
  int         idx = 0;
  int         len = 0;
  logic       took = 1'b0;
  logic       gap = 1'b0;
  initial begin
    buf_data_out = 8'h00;
    buf_valid_out = 1'b0;
    buf_last_out = 1'b0;
  end
  // a byte is taken at the rising edge where valid meets ready
  always @(posedge mclk_in) begin
    took <= buf_valid_out && buf_ready_in;
  end
  // whole frame written first, control byte leads, held until taken
  always @(negedge mclk_in) begin
    if (took) begin
      idx = idx + 1;
    end
    if (go_in) begin
      idx = 0;
      len = len_in;
    end
    if (!buf_valid_out || took) begin
      gap = slow_in && !gap;
      if (idx < len && !gap) begin
        buf_valid_out = 1'b1;
        buf_data_out = mem[idx];
        buf_last_out = (idx == len - 1);
      end else begin
        buf_valid_out = 1'b0;
        buf_last_out = 1'b0;
        buf_data_out = ~buf_data_out; // released lines keep moving
      end
    end
  end
endmodule
`default_nettype wire

// [verification/tb.sv]
// self-checking testbench for the transmit frame control decode block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk_in = 1'b0, rst_in = 1'b1, go = 1'b0, slow = 1'b0;
  logic [7:0] len = 8'h00;
  logic [2:0] cfg_pad_mode_in = 3'h0;
  logic cfg_fcs_enable_in = 1'b0, cfg_oversize_allow_in = 1'b0;
  logic [15:0] max_frame_length_in = 16'h0064;
  wire logic [7:0] buf_data_in, wire_data_out;
  wire logic buf_valid_in, buf_last_in, buf_ready_out, wire_valid_out, wire_end_out;
  wire logic frame_done_out, frame_abort_out, fcs_bad_out, busy_out;
  int err_count = 0, checks_done = 0, aborts = 0, ends = 0;
  logic [7:0] wq [$];
  txfc_tx_frame #(.CNT_W(16)) dut (.mclk_in(mclk_in), .rst_in(rst_in),
    .buf_data_in(buf_data_in), .buf_valid_in(buf_valid_in), .buf_last_in(buf_last_in),
    .buf_ready_out(buf_ready_out), .cfg_pad_mode_in(cfg_pad_mode_in),
    .cfg_fcs_enable_in(cfg_fcs_enable_in), .cfg_oversize_allow_in(cfg_oversize_allow_in),
    .max_frame_length_in(max_frame_length_in), .wire_data_out(wire_data_out),
    .wire_valid_out(wire_valid_out), .wire_end_out(wire_end_out),
    .frame_done_out(frame_done_out), .frame_abort_out(frame_abort_out),
    .fcs_bad_out(fcs_bad_out), .busy_out(busy_out));
  txfc_host_model host (.mclk_in(mclk_in), .go_in(go), .slow_in(slow), .len_in(len),
    .buf_ready_in(buf_ready_out), .buf_data_out(buf_data_in), .buf_valid_out(buf_valid_in),
    .buf_last_out(buf_last_in));
  // clock and wire capture
  initial begin
    forever #2.5 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    if (wire_valid_out === 1'b1) wq.push_back(wire_data_out);
    if (frame_abort_out === 1'b1) aborts++;
    if (wire_end_out === 1'b1) ends++;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  function automatic logic [31:0] crc_next(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    for (int k = 0; k < 8; k++) r = r[0] ? (r >> 1) ^ txfc_pkg::CRC_POLY : r >> 1;
    return r;
  endfunction
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // one frame: globals, control byte, n payload bytes, expected pad target/crc/limit
  task automatic run(input logic [2:0] pm, input logic fc, input logic ov, input logic [15:0] mx,
    input logic [7:0] ctl, input int n, input logic sl, input logic own, input int pad,
    input logic fcs, input logic cap);
    int cnt, t;
    logic [31:0] c;
    logic [7:0] b;
    @(negedge mclk_in);
    cfg_pad_mode_in = pm;
    cfg_fcs_enable_in = fc;
    cfg_oversize_allow_in = ov;
    max_frame_length_in = mx;
    host.mem[0] = ctl;
    for (int i = 1; i <= n; i++) host.mem[i] = 8'(i * 7 + 3);
    // tagged type field for the tag-dependent pad mode
    if (pm == 3'h5 && pad == 64) begin
      host.mem[13] = 8'h81;
      host.mem[14] = 8'h00;
    end
    c = txfc_pkg::CRC_INIT;
    for (int i = 1; i <= n - 4; i++) c = crc_next(c, host.mem[i]);
    for (int k = 0; k < 4; k++) if (own) host.mem[n - 3 + k] = ~c[8 * k +: 8];
    wq.delete();
    aborts = 0;
    ends = 0;
    slow <= sl;
    go <= 1'b1;
    len <= 8'(n + 1);
    @(negedge mclk_in);
    go <= 1'b0;
    t = 0;
    while (frame_done_out !== 1'b1 && t < 500) begin
      @(negedge mclk_in);
      t++;
    end
    @(negedge mclk_in);
    check(t < 500, 1, "frame completion");
    cnt = (cap && n > mx) ? int'(mx) : n;
    if (cnt < pad) cnt = pad;
    check(wq.size(), 8 + cnt + (fcs ? 4 : 0), "wire byte count");
    for (int i = 0; i < 8; i++) check(wq[i], i < 7 ? 8'h55 : 8'hd5, "preamble");
    c = txfc_pkg::CRC_INIT;
    for (int i = 1; i <= cnt; i++) begin
      b = (i <= n) ? host.mem[i] : 8'h00;
      c = crc_next(c, b);
      check(wq[7 + i], b, "frame byte");
    end
    c = ~c;
    for (int k = 0; k < 4; k++) if (fcs) check(wq[8 + cnt + k], c[8 * k +: 8], "crc");
    check(aborts, cap && n > mx, "abort count");
    check(ends, !(cap && n > mx), "end marker count");
    check(busy_out, 1'b0, "busy after frame");
    if (!fcs && !(cap && n > mx)) check(fcs_bad_out, !own, "crc check flag");
    $display("test with control %h done", ctl);
  endtask
  initial begin
    #25000;
    err_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    wrap_up;
  end
  initial begin
    repeat (4) @(negedge mclk_in);
    rst_in = 1'b0;
    run(3'h0, 0, 0, 16'h0064, 8'h07, 20, 0, 0, 60, 1, 1);
    run(3'h1, 1, 1, 16'h0064, 8'hf1, 20, 0, 0, 0, 0, 1);
    run(3'h0, 0, 0, 16'h001e, 8'h0e, 40, 0, 0, 0, 0, 1);
    run(3'h1, 1, 0, 16'h0064, 8'h00, 20, 1, 0, 60, 1, 1);
    run(3'h3, 0, 0, 16'h0064, 8'h00, 20, 0, 0, 64, 0, 1);
    run(3'h5, 1, 0, 16'h0064, 8'h00, 20, 0, 0, 64, 1, 1);
    run(3'h5, 1, 0, 16'h0064, 8'h00, 20, 1, 0, 60, 1, 1);
    run(3'h0, 0, 1, 16'h001e, 8'h01, 40, 0, 0, 0, 0, 1);
    run(3'h0, 1, 0, 16'h001e, 8'h0b, 40, 1, 0, 0, 1, 0);
    run(3'h0, 1, 0, 16'h0064, 8'h01, 24, 0, 1, 0, 0, 1);
    run(3'h0, 0, 0, 16'h0064, 8'h05, 59, 0, 0, 60, 0, 1);
    run(3'h0, 0, 0, 16'h0064, 8'h05, 60, 0, 0, 60, 0, 1);
    wrap_up;
  end
endmodule
bind txfc_tx_frame txfc_tx_frame_props #(.CNT_W(CNT_W)) props (.mclk_in(mclk_in),
  .rst_in(rst_in), .buf_data_in(buf_data_in), .buf_valid_in(buf_valid_in),
  .buf_last_in(buf_last_in), .buf_ready_out(buf_ready_out), .cfg_pad_mode_in(cfg_pad_mode_in),
  .cfg_fcs_enable_in(cfg_fcs_enable_in), .cfg_oversize_allow_in(cfg_oversize_allow_in),
  .max_frame_length_in(max_frame_length_in), .wire_data_out(wire_data_out),
  .wire_valid_out(wire_valid_out), .wire_end_out(wire_end_out),
  .frame_done_out(frame_done_out), .frame_abort_out(frame_abort_out),
  .fcs_bad_out(fcs_bad_out), .busy_out(busy_out));
`default_nettype wire
